/* File: hdl/pll_clock_pkg.sv */
// constants, types and decode functions for the clock receiver and pll setup
package pll_clock_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RX_CTRL    = 8'h08;
    localparam logic [7:0] ADDR_PLL_BAND   = 8'h0A;
    localparam logic [7:0] ADDR_PLL_LOOP   = 8'h0C;
    localparam logic [7:0] ADDR_PLL_DIV    = 8'h0D;
    localparam logic [7:0] ADDR_PLL_STATUS = 8'h0E;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_DCC_CONV = 7;
    localparam int BIT_DCC_REF  = 6;
    localparam int BIT_XC_CONV  = 5;
    localparam int BIT_XC_REF   = 4;
    localparam int BIT_PLL_EN   = 7;
    localparam int BIT_BAND_MAN = 6;
    localparam int BAND_LSB     = 0;
    localparam int BAND_W       = 6;
    localparam int LBW_LSB      = 6;
    localparam int LBW_W        = 2;
    localparam int CP_LSB       = 0;
    localparam int CP_W         = 5;
    localparam int CDIV_LSB     = 6;
    localparam int DIV_W        = 2;
    localparam int BIT_XPC      = 4;
    localparam int VDIV_LSB     = 2;
    localparam int BIT_LOCK     = 7;

    // implemented bits of each register; the rest read as zero
    localparam logic [7:0] MASK_RX   = 8'hF0;
    localparam logic [7:0] MASK_BAND = 8'hFF;
    localparam logic [7:0] MASK_LOOP = 8'hDF;
    localparam logic [7:0] MASK_DIV  = 8'hDC;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic       RST_DCC_CONV  = 1'h0;
    localparam logic       RST_DCC_REF   = 1'h0;
    localparam logic       RST_XC_CONV   = 1'h1;
    localparam logic       RST_XC_REF    = 1'h1;
    localparam logic       RST_PLL_EN    = 1'h0;
    localparam logic       RST_BAND_MAN  = 1'h1;
    localparam logic [5:0] RST_BAND      = 6'h00;
    localparam logic [1:0] RST_LBW       = 2'h3;
    localparam logic [4:0] RST_CP        = 5'h11;
    localparam logic [1:0] RST_CDIV      = 2'h3;
    localparam logic       RST_XPC       = 1'h1;
    localparam logic [1:0] RST_VDIV      = 2'h2;
    localparam logic [2:0] RST_VCO_RATIO = 3'h4;

    typedef logic [1:0] div_code_type;

    // ------------------------------------------------------------------
    // divider decodes
    // ------------------------------------------------------------------
    function automatic logic [4:0] ctrl_div_ratio(input div_code_type code);
        unique case (code)
            2'h0: ctrl_div_ratio = 5'h02;
            2'h1: ctrl_div_ratio = 5'h04;
            2'h2: ctrl_div_ratio = 5'h08;
            2'h3: ctrl_div_ratio = 5'h10;
        endcase
    endfunction : ctrl_div_ratio

    function automatic logic [2:0] vco_div_ratio(input div_code_type code);
        unique case (code)
            2'h0: vco_div_ratio = 3'h1;
            2'h1: vco_div_ratio = 3'h2;
            2'h2: vco_div_ratio = 3'h4;
            2'h3: vco_div_ratio = 3'h4;
        endcase
    endfunction : vco_div_ratio

endpackage : pll_clock_pkg

/* File: hdl/pc_div_if.sv */
// carrier between the register logic and the controller clock divider
`timescale 1ns/100ps
interface pc_div_if;
    import pll_clock_pkg::*;
    div_code_type divCode;
    logic         tick;
    modport ctrl (output divCode, input tick);
    modport div  (input divCode, output tick);
endinterface : pc_div_if

/* File: hdl/pc_clock_divider.sv */
// controller clock divider: one-cycle enable every 2, 4, 8 or 16 cycles
`timescale 1ns/100ps
module pc_clock_divider (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // divider code in, tick out
    pc_div_if.div     pcIf
);
    import pll_clock_pkg::*;

    logic [4:0] count;
    logic [4:0] terminal;

    // no 75 MHz guard here: software owns the code choice
    assign terminal = ctrl_div_ratio(pcIf.divCode) - 5'h01;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // >= lets a code that shrinks mid-count wrap at once, never stall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count     <= 5'h00;
            pcIf.tick <= 1'b0;
        end else if (count >= terminal) begin
            count     <= 5'h00;
            pcIf.tick <= 1'b1;
        end else begin
            count     <= count + 5'h01;
            pcIf.tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [4:0]   gap;
    logic         steady;
    logic         fresh;
    div_code_type prevCode;
    logic         codeChanged;

    assign codeChanged = pcIf.divCode != prevCode;

    // reset leaves the counter as a tick does, so gap restarts alike
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap      <= 5'h00;
            steady   <= 1'b0;
            fresh    <= 1'b1;
            prevCode <= RST_CDIV;
        end else begin
            gap      <= (pcIf.tick || fresh) ? 5'h00 : gap + 5'h01;
            steady   <= pcIf.tick | fresh | (steady & ~codeChanged);
            fresh    <= 1'b0;
            prevCode <= pcIf.divCode;
        end
    end

    a_tick_period: assert property (
        (pcIf.tick && steady && !codeChanged) |-> gap == terminal)
        else $error("controller tick spacing differs from ratio");

    a_tick_gap_max: assert property (
        gap <= 5'h0F)
        else $error("controller tick missing for over 16 cycles");

    a_tick_fastest: assert property (
        ((pcIf.tick && pcIf.divCode == 2'h0) ##1 pcIf.divCode == 2'h0)
        |-> !pcIf.tick ##1 pcIf.tick)
        else $error("divide by two tick pattern broken");

    c_tick_div2: cover property (pcIf.tick && pcIf.divCode == 2'h0);

endmodule : pc_clock_divider

/* File: hdl/pll_clock_receiver_config.sv */
// clock receiver and pll configuration registers with controller clock tick
// Function
// - bit 0x08.7 enables conversion clock duty correction
// - bit 0x08.6 enables reference clock duty correction
// - bit 0x08.5 enables conversion clock crossing correction
// - bit 0x08.4 enables reference clock crossing correction
// - bit 0x0A.7 turns pll on, reference clock
// - manual bit selects software band over automatic
// - bits 0x0A[5:0] hold manual band, reset zero
// - bits 0x0C[7:6] loop bandwidth, reset 11
// - bits 0x0C[4:0] charge pump current, reset 10001
// - bits 0x0D[7:6] divide controller clock by 2..16
// - bit 0x0D.4 enables cross-point controller, reset one
// - bits 0x0D[3:2] vco divider, reset 10, 00=1
// - vco divider 01 gives two, 10/11 four
// - status 0x0E.7 reports pll tracking reference
`timescale 1ns/100ps
module pll_clock_receiver_config (
    // clock and reset
    input  wire  logic       clk,
    input  wire  logic       rst,
    // register access from the serial port logic
    input  wire  logic [7:0] regAddr,
    input  wire  logic [7:0] regWrData,
    input  wire  logic       regWrite,
    input  wire  logic       regRead,
    output logic       [7:0] regRdData,
    output logic             regRdValid,
    // clock receivers
    output logic             dutyCorrConv,
    output logic             dutyCorrRef,
    output logic             crossCorrConv,
    output logic             crossCorrRef,
    // pll settings
    output logic             pllEnable,
    output logic             bandManual,
    output logic       [5:0] manualBand,
    output logic       [5:0] vcoBand,
    output logic       [1:0] loopBandwidth,
    output logic       [4:0] pumpCurrent,
    output pll_clock_pkg::div_code_type controllerClockDivider,
    output logic             crossCtrlEnable,
    output pll_clock_pkg::div_code_type vcoOutputDivider,
    output logic       [2:0] vcoRatio,
    output logic             pllControllerClockTick,
    // analog pll status pins
    input  wire  logic       pllLockedPin,
    input  wire  logic [5:0] autoBandPin
);
    import pll_clock_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // band pins move only during calibration, so per-bit sync is accepted
    logic       lockMeta;
    logic       lockSync;
    logic [5:0] bandMeta;
    logic [5:0] autoBandSync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lockMeta     <= 1'b0;
            lockSync     <= 1'b0;
            bandMeta     <= 6'h00;
            autoBandSync <= 6'h00;
        end else begin
            lockMeta     <= pllLockedPin;
            lockSync     <= lockMeta;
            bandMeta     <= autoBandPin;
            autoBandSync <= bandMeta;
        end
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire wrRx   = regWrite && regAddr == ADDR_RX_CTRL;
    wire wrBand = regWrite && regAddr == ADDR_PLL_BAND;
    wire wrLoop = regWrite && regAddr == ADDR_PLL_LOOP;
    wire wrDiv  = regWrite && regAddr == ADDR_PLL_DIV;
    wire rdLoop = regRead && regAddr == ADDR_PLL_LOOP;
    wire mapped = regAddr == ADDR_RX_CTRL || regAddr == ADDR_PLL_BAND ||
                  regAddr == ADDR_PLL_LOOP || regAddr == ADDR_PLL_DIV ||
                  regAddr == ADDR_PLL_STATUS;

    wire [7:0] rdRx   = {dutyCorrConv, dutyCorrRef, crossCorrConv,
                         crossCorrRef, 4'h0};
    wire [7:0] rdBand = {pllEnable, bandManual, manualBand};
    wire [7:0] rdLp   = {loopBandwidth, 1'h0, pumpCurrent};
    wire [7:0] rdDiv  = {controllerClockDivider, 1'h0, crossCtrlEnable,
                         vcoOutputDivider, 2'h0};
    wire [7:0] rdStat = {lockSync, 7'h00};

    // unused positions are wired to zero above
    wire [7:0] rdMux = (regAddr == ADDR_RX_CTRL)    ? rdRx   :
                       (regAddr == ADDR_PLL_BAND)   ? rdBand :
                       (regAddr == ADDR_PLL_LOOP)   ? rdLp   :
                       (regAddr == ADDR_PLL_DIV)    ? rdDiv  :
                       (regAddr == ADDR_PLL_STATUS) ? rdStat : 8'h00;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dutyCorrConv  <= RST_DCC_CONV;
            dutyCorrRef   <= RST_DCC_REF;
            crossCorrConv <= RST_XC_CONV;
            crossCorrRef  <= RST_XC_REF;
        end else if (wrRx) begin
            dutyCorrConv  <= regWrData[BIT_DCC_CONV];
            dutyCorrRef   <= regWrData[BIT_DCC_REF];
            crossCorrConv <= regWrData[BIT_XC_CONV];
            crossCorrRef  <= regWrData[BIT_XC_REF];
        end
    end

    // pll reference is always the reference clock input when enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pllEnable  <= RST_PLL_EN;
            bandManual <= RST_BAND_MAN;
            manualBand <= RST_BAND;
        end else if (wrBand) begin
            pllEnable  <= regWrData[BIT_PLL_EN];
            bandManual <= regWrData[BIT_BAND_MAN];
            manualBand <= regWrData[BAND_LSB +: BAND_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loopBandwidth <= RST_LBW;
            pumpCurrent   <= RST_CP;
        end else if (wrLoop) begin
            loopBandwidth <= regWrData[LBW_LSB +: LBW_W];
            pumpCurrent   <= regWrData[CP_LSB +: CP_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            controllerClockDivider <= RST_CDIV;
            crossCtrlEnable        <= RST_XPC;
            vcoOutputDivider       <= RST_VDIV;
        end else if (wrDiv) begin
            controllerClockDivider <= regWrData[CDIV_LSB +: DIV_W];
            crossCtrlEnable        <= regWrData[BIT_XPC];
            vcoOutputDivider       <= regWrData[VDIV_LSB +: DIV_W];
        end
    end

    // ------------------------------------------------------------------
    // derived outputs and read port
    // ------------------------------------------------------------------
    // automatic band only counts when software has not taken control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vcoBand    <= RST_BAND;
            vcoRatio   <= RST_VCO_RATIO;
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            vcoBand    <= bandManual ? manualBand : autoBandSync;
            vcoRatio   <= vco_div_ratio(vcoOutputDivider);
            regRdData  <= regRead ? rdMux : 8'h00;
            regRdValid <= regRead;
        end
    end

    // ------------------------------------------------------------------
    // controller clock divider
    // ------------------------------------------------------------------
    pc_div_if pcIf ();

    assign pcIf.divCode           = controllerClockDivider;
    assign pllControllerClockTick = pcIf.tick;

    pc_clock_divider divider (
        .clk  (clk),
        .rst  (rst),
        .pcIf (pcIf.div)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [7:0] wrDataQ;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrDataQ <= 8'h00;
        end else begin
            wrDataQ <= regWrData;
        end
    end

    a_rx_write: assert property (
        wrRx |=> {dutyCorrConv, dutyCorrRef, crossCorrConv, crossCorrRef}
                 == wrDataQ[7:4])
        else $error("receiver control bits not taken from write");

    a_rx_hold: assert property (
        !wrRx |=> $stable({dutyCorrConv, dutyCorrRef, crossCorrConv,
                           crossCorrRef}))
        else $error("receiver control bits changed without write");

    a_pll_enable: assert property (
        wrBand |=> pllEnable == wrDataQ[BIT_PLL_EN])
        else $error("pll enable not taken from write");

    a_band_manual: assert property (
        bandManual |=> vcoBand == $past(manualBand))
        else $error("manual band not used in manual mode");

    a_band_auto: assert property (
        !bandManual |=> vcoBand == $past(autoBandSync))
        else $error("automatic band not used in automatic mode");

    a_band_write: assert property (
        wrBand |=> manualBand == wrDataQ[BAND_LSB +: BAND_W] ##1
                   $stable(manualBand) || $past(wrBand))
        else $error("manual band field not written or not held");

    a_loop_write: assert property (
        wrLoop |=> loopBandwidth == wrDataQ[LBW_LSB +: LBW_W] &&
                   pumpCurrent == wrDataQ[CP_LSB +: CP_W])
        else $error("loop filter or pump field not written");

    a_div_write: assert property (
        wrDiv |=> {controllerClockDivider, crossCtrlEnable,
                   vcoOutputDivider} ==
                  {wrDataQ[7:6], wrDataQ[4], wrDataQ[3:2]})
        else $error("divider register fields not written");

    a_vco_ratio: assert property (
        ##1 vcoRatio == ($past(vcoOutputDivider) == 2'h0 ? 3'h1 :
                         $past(vcoOutputDivider) == 2'h1 ? 3'h2 : 3'h4))
        else $error("vco ratio does not follow divider code");

    a_lock_read: assert property (
        (regRead && regAddr == ADDR_PLL_STATUS) |=>
        regRdValid && regRdData == {$past(lockSync), 7'h00})
        else $error("status read does not show lock state");

    a_loop_readback: assert property (
        (wrLoop ##1 (rdLoop && !wrLoop)) |=>
        regRdData == ($past(regWrData, 2) & MASK_LOOP))
        else $error("loop register does not read back last write");

    a_unmapped_zero: assert property (
        (regRead && !mapped) |=> regRdValid && regRdData == 8'h00)
        else $error("unmapped read returned nonzero data");

    c_manual_band: cover property (wrBand && regWrData[BIT_BAND_MAN]);
    c_auto_band: cover property (wrBand && !regWrData[BIT_BAND_MAN]);
    c_lock_seen: cover property (
        regRead && regAddr == ADDR_PLL_STATUS && lockSync);
    c_div_readback: cover property (wrDiv ##1 regRead);

endmodule : pll_clock_receiver_config

/* File: tb/pll_clock_receiver_config_tb_top.sv */
// self-checking bench for the clock receiver and pll setup registers
`timescale 1ns/100ps
module pll_clock_receiver_config_tb_top;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk          = 1'b0;
    logic        rst          = 1'b1;
    logic [7:0]  regAddr      = 8'h00;
    logic [7:0]  regWrData    = 8'h00;
    logic        regWrite     = 1'b0;
    logic        regRead      = 1'b0;
    logic        pllLockedPin = 1'b0;
    logic [5:0]  autoBandPin  = 6'h00;
    logic [7:0]  regRdData;
    logic        regRdValid;
    logic        dutyCorrConv;
    logic        dutyCorrRef;
    logic        crossCorrConv;
    logic        crossCorrRef;
    logic        pllEnable;
    logic        bandManual;
    logic [5:0]  manualBand;
    logic [5:0]  vcoBand;
    logic [1:0]  loopBandwidth;
    logic [4:0]  pumpCurrent;
    logic [1:0]  controllerClockDivider;
    logic        crossCtrlEnable;
    logic [1:0]  vcoOutputDivider;
    logic [2:0]  vcoRatio;
    logic        pllControllerClockTick;
    int          bad_count    = 0;
    int          tests_run    = 0;
    int          cycles       = 0;
    logic [31:0] seed         = 32'h6D80;
    logic [7:0]  adr [4]      = '{8'h08, 8'h0A, 8'h0C, 8'h0D};
    logic [7:0]  sh  [4]      = '{8'h30, 8'h40, 8'hD1, 8'hD8};

    always #5 clk = ~clk;

    pll_clock_receiver_config dut (
        .clk                    (clk),
        .rst                    (rst),
        .regAddr                (regAddr),
        .regWrData              (regWrData),
        .regWrite               (regWrite),
        .regRead                (regRead),
        .regRdData              (regRdData),
        .regRdValid             (regRdValid),
        .dutyCorrConv           (dutyCorrConv),
        .dutyCorrRef            (dutyCorrRef),
        .crossCorrConv          (crossCorrConv),
        .crossCorrRef           (crossCorrRef),
        .pllEnable              (pllEnable),
        .bandManual             (bandManual),
        .manualBand             (manualBand),
        .vcoBand                (vcoBand),
        .loopBandwidth          (loopBandwidth),
        .pumpCurrent            (pumpCurrent),
        .controllerClockDivider (controllerClockDivider),
        .crossCtrlEnable        (crossCtrlEnable),
        .vcoOutputDivider       (vcoOutputDivider),
        .vcoRatio               (vcoRatio),
        .pllControllerClockTick (pllControllerClockTick),
        .pllLockedPin           (pllLockedPin),
        .autoBandPin            (autoBandPin)
    );

    // ------------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // unused bit positions must come back as zero
    function automatic logic [7:0] expv(input int i, input logic [7:0] d);
        case (i)
            0:       return d & 8'hF0;
            2:       return d & 8'hDF;
            3:       return d & 8'hDC;
            default: return d;
        endcase
    endfunction : expv

    function automatic logic [7:0] vco_exp(input logic [1:0] c);
        return (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h02 : 8'h04;
    endfunction : vco_exp

    function automatic logic [7:0] outs(input int i);
        case (i)
            0: return {dutyCorrConv, dutyCorrRef, crossCorrConv,
                       crossCorrRef, 4'h0};
            1: return {pllEnable, bandManual, manualBand};
            2: return {loopBandwidth, 1'b0, pumpCurrent};
            default: return {controllerClockDivider, 1'b0, crossCtrlEnable,
                             vcoOutputDivider, 2'h0};
        endcase
    endfunction : outs

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (adr[i] == a) begin
                sh[i] = d;
            end
        end
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk({7'h00, regRdValid}, 8'h01);
        chk(regRdData, e);
        @(posedge clk);
        #1;
        chk({7'h00, regRdValid}, 8'h00);
        chk(regRdData, 8'h00);
        @(posedge clk);
    endtask : rd

    task automatic check_fields;
        #1;
        for (int i = 0; i < 4; i++) begin
            chk(outs(i), expv(i, sh[i]));
        end
        chk({5'h00, vcoRatio}, vco_exp(sh[3][3:2]));
    endtask : check_fields

    task automatic tick_gap(input logic [1:0] code);
        int n;
        wr(8'h0D, {code, 6'h18});
        #1;
        n = 0;
        while (pllControllerClockTick !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pllControllerClockTick !== 1'b1 && n < 40);
        chk(n[7:0], 8'h02 << code);
        @(posedge clk);
    endtask : tick_gap

    // a hang counts against the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_fields();
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], expv(i, sh[i]));
        end
        // random writes with readback, corner values mixed in
        for (int k = 0; k < 28; k++) begin
            int i;
            logic [7:0] d;
            seed = xs(seed);
            i = seed[9:8];
            d = (k < 4) ? 8'hFF : (k < 8) ? 8'h00 : seed[7:0];
            if (k < 8) begin
                i = k % 4;
            end
            wr(adr[i], d);
            check_fields();
            @(posedge clk);
            rd(adr[i], expv(i, d));
        end
        // status register is read-only and follows the lock pin
        wr(8'h0E, 8'hFF);
        check_fields();
        @(posedge clk);
        pllLockedPin <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h0E, 8'h80);
        pllLockedPin <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h0E, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h3B, 8'h00);
        // band source: automatic pins versus manual field
        autoBandPin <= 6'h2A;
        wr(8'h0A, 8'h95);
        repeat (4) @(posedge clk);
        #1;
        chk({2'h0, vcoBand}, 8'h2A);
        @(posedge clk);
        wr(8'h0A, 8'hD5);
        repeat (2) @(posedge clk);
        #1;
        chk({2'h0, vcoBand}, 8'h15);
        @(posedge clk);
        // fastest tick here is 50 MHz, inside the controller limit
        for (int c = 0; c < 4; c++) begin
            tick_gap(c[1:0]);
        end
        // reset in mid-run brings every field back to its default
        rst <= 1'b1;
        sh = '{8'h30, 8'h40, 8'hD1, 8'hD8};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // first read lands on the first edge after release
        rd(8'h0D, 8'hD8);
        check_fields();
        end_sim();
    end

endmodule : pll_clock_receiver_config_tb_top
